// ---- hdl/strbc_core.sv ----
// serial transmit/receive engine with baud generation and Avalon-MM register slave
`timescale 1ns/1ps
`include "strbc_defs.svh"

// Functional notes
// - sync mode bit clock is source divided by divisor
// - sync with external source uses clock pin directly
// - divided clock duty near 50:50 on pin
// - card mode divides source, optional clock output
// - card bit time divides card clock by ratio
// - ratio field resets to 372
// - receiver and transmitter disabled after reset
// - soft reset halts direction, keeps configuration
// - receiver disable waits for character end
// - transmitter disable waits for holding and shift
// - frame start, data, parity, stop on falling edges
// - nine-bit select overrides character length
// - bit order select one sends MSB first
// - stop count honoured, one-and-half async only
// - holding moves to shifter, holding empty flag rises
// - transmit flags low when disabled, full writes discarded
// - async receiver oversamples by sixteen or eight
// - start after half-bit lows, then bit spacing
// - receiver checks one stop, hunts immediately
// - divisor zero stops clock, one bypasses
// - async sampling clock divided to bit rate
// - finished character goes to holding, ready flag
module strbc_core
  import strbc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // serial line
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        rxd,
  output logic             txd
);

  function automatic logic [3:0] bitPos(input logic [3:0] idx, input logic [3:0] len,
                                        input logic msb);
    bitPos = msb ? 4'(len - 4'h1 - idx) : idx;
  endfunction : bitPos
  function automatic logic [8:0] lenMask(input logic [3:0] len);
    lenMask = 9'(~(10'h3FF << len));
  endfunction : lenMask
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] m;
    m       = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    beMerge = (wd & m) | (old & ~m);
  endfunction : beMerge

  // clock edge memory starts at the pin's idle level, so no false edge follows reset
  localparam strbc_state_s ST_RESET = '{
    ratio:   `SB_RATIO_RST,
    txState: TX_IDLE,
    rxState: RX_HUNT,
    txd:     1'b1,
    sckPrev: 1'b1,
    waitReq: 1'b1,
    default: '0
  };
  logic [1:0]   rstSync;
  logic         srstN;
  strbc_state_s s;
  strbc_state_s next_s;

  // reset released through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign srstN = rstSync[1];

  // clock selection and baud derivation
  logic        isIso;
  logic        isSync;
  logic        extDirect;
  logic        extRise;
  logic        extFall;
  logic        srcTick;
  logic [15:0] cdHalf;
  logic        divWrap;
  logic        riseTick;
  logic        txTick;
  logic        rxTick;
  logic [11:0] bitLen;
  logic [11:0] halfLen;
  logic [11:0] stopLen;
  logic [11:0] txCurLen;
  logic [3:0]  dataLen;
  logic        parOn;
  logic        parBit;
  logic        holdingEmpty;
  logic        allSent;
  logic        acc;
  logic [31:0] rdMux;

  assign isIso     = s.modeReg[`SB_MR_USMODE] == `SB_USMODE_ISO;
  assign isSync    = s.modeReg[`SB_MR_SYNC] & ~isIso;
  assign extDirect = isSync & (s.modeReg[`SB_MR_SRC] == `SB_SRC_EXT);
  assign extRise   = sckIn & ~s.sckPrev;
  assign extFall   = ~sckIn & s.sckPrev;

  assign srcTick = (s.modeReg[`SB_MR_SRC] == `SB_SRC_DIV) ? (s.preCnt == `SB_PRE_MAX) :
                   (s.modeReg[`SB_MR_SRC] == `SB_SRC_EXT) ? extRise : 1'b1;

  // zero divisor never wraps, so no divider ticks; only the direct external clock still ticks
  assign cdHalf   = s.divisor >> 1;
  assign divWrap  = srcTick & (s.divisor != 16'h0000) &
                    (s.divCnt >= 16'(s.divisor - 16'h0001));
  assign riseTick = (s.divisor == 16'h0001) ? divWrap :
                    srcTick & (s.divisor != 16'h0000) &
                    (s.divCnt == 16'(cdHalf - 16'h0001));

  // sampling clock to bit length: oversampling, card ratio or one
  assign bitLen  = isIso ? {1'b0, s.ratio} :
                   isSync ? `SB_SYNC_LEN :
                   s.modeReg[`SB_MR_OVER] ? `SB_OVS8 : `SB_OVS16;
  assign halfLen = ((bitLen >> 1) == 12'h000) ? `SB_SYNC_LEN : (bitLen >> 1);
  assign txTick  = extDirect ? extFall : divWrap;
  assign rxTick  = extDirect ? extRise : isSync ? riseTick : divWrap;
  assign stopLen = (s.modeReg[`SB_MR_STOP] == `SB_STOP_2) ? 12'(bitLen << 1) :
                   (s.modeReg[`SB_MR_STOP] == `SB_STOP_1P5 && !isSync && !isIso) ?
                   12'(bitLen + (bitLen >> 1)) : bitLen;
  assign txCurLen = (s.txState == TX_STOP) ? stopLen : bitLen;

  assign dataLen = s.modeReg[`SB_MR_NINE] ? `SB_LEN_NINE :
                   4'(`SB_LEN_MIN + {2'b00, s.modeReg[`SB_MR_CHAR_LENGTH_FIELD]});
  assign parOn   = s.modeReg[`SB_MR_PAR] < `SB_PAR_NONE;
  assign parBit  = (s.modeReg[`SB_MR_PAR] == `SB_PAR_MARK) |
                   ((s.modeReg[`SB_MR_PAR] == `SB_PAR_EVEN) & ^(s.txData & lenMask(dataLen))) |
                   ((s.modeReg[`SB_MR_PAR] == `SB_PAR_ODD) & ~^(s.txData & lenMask(dataLen)));

  assign holdingEmpty = s.transmitter_enable_cmd & ~s.thrFull;
  assign allSent      = holdingEmpty & (s.txState == TX_IDLE);

  assign acc = (read | write) & ~s.waitReq;

  always_comb
  begin
    rdMux = 32'h00000000;
    unique case (address)
      `SB_OFS_MODE:   rdMux = s.modeReg;
      `SB_OFS_DIV:    rdMux = {16'h0000, s.divisor};
      `SB_OFS_RATIO:  rdMux = {21'h000000, s.ratio};
      `SB_OFS_RHR:    rdMux = {23'h000000, s.rhr};
      `SB_OFS_STATUS:
      begin
        rdMux[`SB_ST_RECEIVE_READY_FLAG]   = s.rxReady;
        rdMux[`SB_ST_HOLDING_EMPTY_FLAG]   = holdingEmpty;
        rdMux[`SB_ST_ALL_SENT_FLAG] = allSent;
      end
      default:        rdMux = 32'h00000000;
    endcase
  end

  always_comb
  begin
    logic loadNow;
    loadNow = 1'b0;
    next_s  = s;

    // bus slave: one wait cycle, then accepted
    if (s.waitReq && (read || write))
    begin
      next_s.waitReq = 1'b0;
      next_s.rdata   = rdMux;
    end
    else
      next_s.waitReq = 1'b1;

    if (acc && write)
    begin
      unique case (address)
        `SB_OFS_MODE:  next_s.modeReg = beMerge(s.modeReg, writedata, byteenable) & `SB_MR_MASK;
        `SB_OFS_DIV:   next_s.divisor = 16'(beMerge({16'h0000, s.divisor}, writedata,
                                                    byteenable));
        `SB_OFS_RATIO: next_s.ratio   = 11'(beMerge({21'h000000, s.ratio}, writedata,
                                                    byteenable));
        `SB_OFS_THR:
        begin
          if (holdingEmpty && byteenable[0])
          begin
            next_s.thr     = writedata[8:0];
            next_s.thrFull = 1'b1;
          end
        end
        `SB_OFS_CMD:
        begin
          if (byteenable[0])
          begin
            if (writedata[`SB_CMD_TRANSMITTER_ENABLE_CMD])
              next_s.transmitter_enable_cmd = 1'b1;
            if (writedata[`SB_CMD_RECEIVER_ENABLE_CMD])
              next_s.receiver_enable_cmd = 1'b1;
            if (writedata[`SB_CMD_TRANSMITTER_DISABLE_CMD] && s.transmitter_enable_cmd)
              next_s.txDisPend = 1'b1;
            if (writedata[`SB_CMD_RECEIVER_DISABLE_CMD] && s.receiver_enable_cmd)
              next_s.rxDisPend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // reading the holding register clears ready; a new character below wins
    if (acc && read && address == `SB_OFS_RHR)
      next_s.rxReady = 1'b0;

    // pre-divider and main divider
    next_s.preCnt  = 3'(s.preCnt + 3'h1);
    next_s.sckPrev = sckIn;
    if (s.divisor == 16'h0000)
      next_s.divCnt = 16'h0000;
    else if (divWrap)
      next_s.divCnt = 16'h0000;
    else if (srcTick)
      next_s.divCnt = 16'(s.divCnt + 16'h0001);
    // high half ends on the wrap, so the falling edge meets the tx tick
    next_s.sckOut = (s.divisor > 16'h0001) && (next_s.divCnt >= cdHalf);
    next_s.sckOe  = s.modeReg[`SB_MR_CLOCK_OUTPUT_ENABLE] &&
                    (s.modeReg[`SB_MR_SRC] != `SB_SRC_EXT);

    // transmitter
    if (!s.transmitter_enable_cmd)
    begin
      next_s.txState = TX_IDLE;
      next_s.txd     = 1'b1;
    end
    else if (txTick)
    begin
      if (s.txState == TX_IDLE)
        loadNow = s.thrFull;
      else if (s.txCnt != 12'(txCurLen - 12'h001))
        next_s.txCnt = 12'(s.txCnt + 12'h001);
      else
      begin
        next_s.txCnt = 12'h000;
        unique case (s.txState)
          TX_START:
          begin
            next_s.txState = TX_DATA;
            next_s.txIdx   = 4'h0;
            next_s.txd     = s.txData[bitPos(4'h0, dataLen, s.modeReg[`SB_MR_BIT_ORDER_SELECT])];
          end
          TX_DATA:
          begin
            if (s.txIdx == 4'(dataLen - 4'h1))
            begin
              next_s.txState = parOn ? TX_PAR : TX_STOP;
              next_s.txd     = parOn ? parBit : 1'b1;
            end
            else
            begin
              next_s.txIdx = 4'(s.txIdx + 4'h1);
              next_s.txd   = s.txData[bitPos(next_s.txIdx, dataLen,
                                             s.modeReg[`SB_MR_BIT_ORDER_SELECT])];
            end
          end
          TX_PAR:
          begin
            next_s.txState = TX_STOP;
            next_s.txd     = 1'b1;
          end
          TX_STOP:
          begin
            next_s.txState = TX_IDLE;
            loadNow        = s.thrFull; // back to back, no idle gap
          end
          default: next_s.txState = TX_IDLE;
        endcase
      end
      if (loadNow)
      begin
        next_s.txData  = s.thr & lenMask(dataLen);
        next_s.thrFull = 1'b0;
        next_s.txState = TX_START;
        next_s.txCnt   = 12'h000;
        next_s.txd     = 1'b0;
      end
    end
    // disable only once shifter and holding register are both empty
    if (next_s.txDisPend && next_s.txState == TX_IDLE && !next_s.thrFull)
    begin
      next_s.transmitter_enable_cmd      = 1'b0;
      next_s.txDisPend = 1'b0;
    end

    // receiver
    if (!s.receiver_enable_cmd)
    begin
      next_s.rxState = RX_HUNT;
      next_s.rxCnt   = 12'h000;
    end
    else if (rxTick)
    begin
      if (s.rxState == RX_HUNT)
      begin
        if (rxd)
          next_s.rxCnt = 12'h000;
        else if (12'(s.rxCnt + 12'h001) >= halfLen)
        begin
          next_s.rxState = RX_DATA;
          next_s.rxCnt   = 12'h000;
          next_s.rxIdx   = 4'h0;
          next_s.rxShift = 9'h000;
        end
        else
          next_s.rxCnt = 12'(s.rxCnt + 12'h001);
      end
      else if (s.rxCnt != 12'(bitLen - 12'h001))
        next_s.rxCnt = 12'(s.rxCnt + 12'h001);
      else
      begin
        next_s.rxCnt = 12'h000;
        unique case (s.rxState)
          RX_DATA:
          begin
            next_s.rxShift[bitPos(s.rxIdx, dataLen, s.modeReg[`SB_MR_BIT_ORDER_SELECT])] = rxd;
            if (s.rxIdx == 4'(dataLen - 4'h1))
              next_s.rxState = parOn ? RX_PAR : RX_STOP;
            else
              next_s.rxIdx = 4'(s.rxIdx + 4'h1);
          end
          RX_PAR:  next_s.rxState = RX_STOP;
          RX_STOP:
          begin
            next_s.rhr     = s.rxShift & lenMask(dataLen);
            next_s.rxReady = 1'b1;
            next_s.rxState = RX_HUNT;
          end
          default: next_s.rxState = RX_HUNT;
        endcase
      end
    end
    if (next_s.rxDisPend && next_s.rxState == RX_HUNT)
    begin
      next_s.receiver_enable_cmd      = 1'b0;
      next_s.rxDisPend = 1'b0;
    end

    // soft resets override everything in their direction
    if (acc && write && address == `SB_OFS_CMD && byteenable[0])
    begin
      if (writedata[`SB_CMD_TXRST])
      begin
        next_s.transmitter_enable_cmd      = 1'b0;
        next_s.txDisPend = 1'b0;
        next_s.thrFull   = 1'b0;
        next_s.txState   = TX_IDLE;
        next_s.txCnt     = 12'h000;
        next_s.txd       = 1'b1;
      end
      if (writedata[`SB_CMD_RXRST])
      begin
        next_s.receiver_enable_cmd      = 1'b0;
        next_s.rxDisPend = 1'b0;
        next_s.rxReady   = 1'b0;
        next_s.rxState   = RX_HUNT;
        next_s.rxCnt     = 12'h000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge srstN)
  begin
    if (!srstN)
      s <= ST_RESET;
    else
      s <= next_s;
  end

  assign readdata    = s.rdata;
  assign waitrequest = s.waitReq;
  assign sckOut      = s.sckOut;
  assign sckOe       = s.sckOe;
  assign txd         = s.txd;

endmodule : strbc_core

// ---- common/strbc_defs.svh ----
// register map, field positions, reset values and timing constants of the serial core
`ifndef STRBC_DEFS_SVH
`define STRBC_DEFS_SVH

// byte offsets on the register bus
`define SB_OFS_CMD      8'h00
`define SB_OFS_MODE     8'h04
`define SB_OFS_DIV      8'h08
`define SB_OFS_RATIO    8'h0C
`define SB_OFS_STATUS   8'h10
`define SB_OFS_THR      8'h14
`define SB_OFS_RHR      8'h18

// command register bits
`define SB_CMD_RXRST    2
`define SB_CMD_TXRST    3
`define SB_CMD_RECEIVER_ENABLE_CMD     4
`define SB_CMD_RECEIVER_DISABLE_CMD    5
`define SB_CMD_TRANSMITTER_ENABLE_CMD     6
`define SB_CMD_TRANSMITTER_DISABLE_CMD    7

// mode register fields
`define SB_MR_USMODE    3:0
`define SB_MR_SRC       5:4
`define SB_MR_CHAR_LENGTH_FIELD      7:6
`define SB_MR_SYNC      8
`define SB_MR_PAR       11:9
`define SB_MR_STOP      13:12
`define SB_MR_BIT_ORDER_SELECT      16
`define SB_MR_NINE      17
`define SB_MR_CLOCK_OUTPUT_ENABLE      18
`define SB_MR_OVER      19
`define SB_MR_MASK      32'h000F3FFF

// field encodings
`define SB_USMODE_ISO   4'h4
`define SB_SRC_MCK      2'h0
`define SB_SRC_DIV      2'h1
`define SB_SRC_EXT      2'h3
`define SB_PAR_EVEN     3'h0
`define SB_PAR_ODD      3'h1
`define SB_PAR_SPACE    3'h2
`define SB_PAR_MARK     3'h3
`define SB_PAR_NONE     3'h4
`define SB_STOP_1P5     2'h1
`define SB_STOP_2       2'h2

// status register bits
`define SB_ST_RECEIVE_READY_FLAG     0
`define SB_ST_HOLDING_EMPTY_FLAG     1
`define SB_ST_ALL_SENT_FLAG   9

// reset values and timing
`define SB_RATIO_RST    11'h174
`define SB_PRE_MAX      3'h7
`define SB_OVS16        12'h010
`define SB_OVS8         12'h008
`define SB_SYNC_LEN     12'h001
`define SB_LEN_MIN      4'h5
`define SB_LEN_NINE     4'h9

`endif

// ---- common/strbc_pkg.sv ----
// types shared by the serial transmit/receive core
package strbc_pkg;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_PAR   = 3'b010,
    TX_STOP  = 3'b110
  } strbc_tx_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_DATA = 2'b01,
    RX_PAR  = 2'b11,
    RX_STOP = 2'b10
  } strbc_rx_e;

  typedef struct packed {
    logic [31:0] modeReg;
    logic [15:0] divisor;
    logic [10:0] ratio;
    logic        transmitter_enable_cmd;
    logic        receiver_enable_cmd;
    logic        txDisPend;
    logic        rxDisPend;
    logic [2:0]  preCnt;
    logic [15:0] divCnt;
    logic        sckPrev;
    logic        sckOut;
    logic        sckOe;
    strbc_tx_e   txState;
    logic [11:0] txCnt;
    logic [3:0]  txIdx;
    logic [8:0]  txData;
    logic [8:0]  thr;
    logic        thrFull;
    logic        txd;
    strbc_rx_e   rxState;
    logic [11:0] rxCnt;
    logic [3:0]  rxIdx;
    logic [8:0]  rxShift;
    logic [8:0]  rhr;
    logic        rxReady;
    logic        waitReq;
    logic [31:0] rdata;
  } strbc_state_s;

endpackage : strbc_pkg

// ---- testbench/strbc_core_checker.sv ----
// port-level checks for the serial core, bound into its top module
`timescale 1ns/1ps
`include "strbc_defs.svh"
module strbc_core_checker
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // serial line
  input wire logic        sckIn,
  input wire logic        sckOut,
  input wire logic        sckOe,
  input wire logic        rxd,
  input wire logic        txd
);
  logic        wrAck;
  logic        rdAck;
  logic        oeWant;
  logic        txOn;
  logic [31:0] modeSh;
  logic [15:0] divSh;
  logic [10:0] ratioSh;

  assign wrAck  = write && !waitrequest;
  assign rdAck  = read && !waitrequest;
  assign oeWant = modeSh[`SB_MR_CLOCK_OUTPUT_ENABLE] && (modeSh[`SB_MR_SRC] != `SB_SRC_EXT);

  // shadow of software setup; full byte lanes assumed, as the bench always uses
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txOn    <= 1'b0;
      modeSh  <= 32'h0;
      divSh   <= 16'h0;
      ratioSh <= `SB_RATIO_RST;
    end
    else if (wrAck)
    begin
      if (address == `SB_OFS_CMD)
        txOn <= !writedata[`SB_CMD_TXRST] && (writedata[`SB_CMD_TRANSMITTER_ENABLE_CMD] || txOn);
      if (address == `SB_OFS_MODE)
        modeSh <= writedata & `SB_MR_MASK;
      if (address == `SB_OFS_DIV)
        divSh <= writedata[15:0];
      if (address == `SB_OFS_RATIO)
        ratioSh <= writedata[10:0];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sReq;
    $rose(read || write);
  endsequence
  sequence sAnswer;
    !waitrequest ##1 waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (sReq |=> sAnswer)
    else $error("bus answer not a single cycle after request");
  AST_ANSWER_CAUSE: assert property (!waitrequest |-> $past(read || write))
    else $error("bus answer without request");
  AST_RATIO_READ: assert property (
    rdAck && address == `SB_OFS_RATIO |-> readdata == {21'h0, ratioSh})
    else $error("ratio readback wrong");
  AST_MODE_KEPT: assert property (
    rdAck && address == `SB_OFS_MODE |-> readdata == modeSh)
    else $error("mode readback wrong");
  AST_TX_FLAGS_OFF: assert property (
    rdAck && address == `SB_OFS_STATUS && !txOn |-> !readdata[1] && !readdata[9])
    else $error("transmit flags set while disabled");
  AST_IDLE_HIGH: assert property (!txOn [*3] |-> txd)
    else $error("transmit line low while transmitter off");
  AST_NO_DIV_CLOCK: assert property ((divSh <= 16'h0001) [*3] |-> !sckOut)
    else $error("serial clock toggles with divisor 0 or 1");
  AST_OE_ON: assert property (oeWant [*3] |-> sckOe)
    else $error("clock pin not driven");
  AST_OE_OFF: assert property (!oeWant [*3] |-> !sckOe)
    else $error("clock pin driven unexpectedly");
endmodule : strbc_core_checker

bind strbc_core strbc_core_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .rxd(rxd),
  .txd(txd)
);

// ---- testbench/strbc_remote.sv ----
// far-end serial transceiver: drives receive line and external clock, captures frames
`timescale 1ns/1ps
module strbc_remote
(
  // clock
  input  wire logic core_clk,
  // serial line
  input  wire logic txd,
  output logic      rxd,
  output logic      sckIn
);
  logic clkRun;
  int   sckCnt;

  initial
  begin
    rxd    = 1'b1;
    sckIn  = 1'b1;
    clkRun = 1'b0;
    sckCnt = 0;
  end

  // ten-cycle period, five low and five high; clock stands high outside frames
  always @(posedge core_clk)
  begin
    sckCnt <= (clkRun && sckCnt < 9) ? sckCnt + 1 : 0;
    sckIn  <= !clkRun || sckCnt >= 5;
  end

  task automatic send(input logic [8:0] d, input int nb, input int len);
    rxd <= 1'b0;
    repeat (len) @(posedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= d[i];
      repeat (len) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (len) @(posedge core_clk);
  endtask : send

  // samples start, data and one stop; async at mid-bit, sync at clock rise
  task automatic grab(input int nb, input int len, input logic sync, output logic [10:0] bits);
    int   n;
    int   i;
    logic prev;
    bits = '1;
    n    = 0;
    i    = 0;
    prev = sckIn;
    while (i < nb + 2 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
      if (sync && sckIn && !prev && (i > 0 || !txd))
      begin
        bits[i] = txd;
        i++;
      end
      else if (!sync && i == 0 && !txd)
      begin
        repeat (len / 2) @(posedge core_clk);
        bits[0] = txd;
        for (i = 1; i < nb + 2; i++)
        begin
          repeat (len) @(posedge core_clk);
          bits[i] = txd;
        end
      end
      prev = sckIn;
    end
  endtask : grab
endmodule : strbc_remote

// ---- testbench/strbc_core_tb.sv ----
// self-checking bench for the serial transmit/receive core
`timescale 1ns/1ps
`include "strbc_defs.svh"
module strbc_core_tb;
  localparam logic [31:0] MODE_ASYNC = 32'h000848C0;
  localparam logic [31:0] MODE_NINE  = 32'h000B08C0;
  localparam logic [31:0] MODE_SYNC  = 32'h000009F0;
  localparam logic [31:0] MODE_CARD  = 32'h000408C4;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        sckIn;
  logic        sckOut;
  logic        sckOe;
  logic        rxd;
  logic        txd;
  int          mismatches;
  int          checkCount;

  strbc_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .rxd(rxd),
    .txd(txd)
  );
  strbc_remote peer (.core_clk(core_clk), .txd(txd), .rxd(rxd), .sckIn(sckIn));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    q = readdata;
    check({31'h0, n < 20}, 32'h1, "bus answer");
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  function automatic logic [31:0] frame(input logic [8:0] d, input int nb, input logic msb);
    frame = 32'h7FF;
    frame[0] = 1'b0;
    for (int i = 0; i < nb; i++)
      frame[i + 1] = msb ? d[nb - 1 - i] : d[i];
  endfunction : frame

  task t_reset_state;
    logic [31:0] q;
    rd(`SB_OFS_RATIO, q);
    check(q, 32'h174, "ratio after reset");
    rd(`SB_OFS_STATUS, q);
    check(q, 32'h0, "status after reset");
    rd(8'h1C, q);
    check(q, 32'h0, "unmapped read");
  endtask : t_reset_state

  // third write meets a full holding register; disable must still send both
  task t_async_disable;
    logic [10:0] a;
    logic [10:0] b;
    logic [31:0] q;
    int          n;
    wr(`SB_OFS_MODE, MODE_ASYNC);
    wr(`SB_OFS_DIV, 32'h1);
    wr(`SB_OFS_CMD, 32'h40);
    fork
      begin
        peer.grab(8, 8, 1'b0, a);
        peer.grab(8, 8, 1'b0, b);
      end
      begin
        wr(`SB_OFS_THR, 32'hA5);
        wr(`SB_OFS_THR, 32'h3C);
        wr(`SB_OFS_THR, 32'hFF);
        wr(`SB_OFS_CMD, 32'h80);
      end
    join
    check({21'h0, a}, frame(9'h0A5, 8, 1'b0), "first frame");
    check({21'h0, b}, frame(9'h03C, 8, 1'b0), "held frame");
    n = 0;
    repeat (200)
    begin
      @(posedge core_clk);
      n += !txd;
    end
    check(n, 0, "discarded char sent");
    rd(`SB_OFS_STATUS, q);
    check(q & 32'h202, 32'h0, "flags after disable");
  endtask : t_async_disable

  task t_nine_msb;
    logic [10:0] a;
    logic [31:0] q;
    wr(`SB_OFS_MODE, MODE_NINE);
    wr(`SB_OFS_CMD, 32'h40);
    fork
      peer.grab(9, 8, 1'b0, a);
      wr(`SB_OFS_THR, 32'h1A5);
    join
    check({21'h0, a}, frame(9'h1A5, 9, 1'b1), "nine bit msb frame");
    repeat (20) @(posedge core_clk);
    rd(`SB_OFS_STATUS, q);
    check(q & 32'h203, 32'h202, "flags when idle");
  endtask : t_nine_msb

  task t_soft_reset;
    logic [31:0] q;
    wr(`SB_OFS_THR, 32'h0);
    repeat (20) @(posedge core_clk);
    wr(`SB_OFS_CMD, 32'h08);
    check({31'h0, txd}, 32'h1, "line after soft reset");
    rd(`SB_OFS_STATUS, q);
    check(q & 32'h202, 32'h0, "flags after soft reset");
    rd(`SB_OFS_MODE, q);
    check(q, MODE_NINE, "mode kept");
  endtask : t_soft_reset

  task t_receive;
    logic [31:0] q;
    wr(`SB_OFS_MODE, MODE_ASYNC);
    wr(`SB_OFS_CMD, 32'h10);
    peer.send(9'h03C, 8, 8);
    peer.send(9'h05A, 8, 8);
    rd(`SB_OFS_STATUS, q);
    check(q & 32'h1, 32'h1, "receive ready");
    rd(`SB_OFS_RHR, q);
    check(q, 32'h5A, "back to back char");
    rd(`SB_OFS_STATUS, q);
    check(q & 32'h1, 32'h0, "ready cleared by read");
    fork
      peer.send(9'h096, 8, 8);
      begin
        repeat (20) @(posedge core_clk);
        wr(`SB_OFS_CMD, 32'h20);
      end
    join
    peer.send(9'h011, 8, 8);
    rd(`SB_OFS_RHR, q);
    check(q, 32'h96, "char finished after disable");
  endtask : t_receive

  // divisor 0 on purpose: the external clock must not depend on it
  task t_sync_ext;
    logic [10:0] a;
    wr(`SB_OFS_DIV, 32'h0);
    wr(`SB_OFS_MODE, MODE_SYNC);
    wr(`SB_OFS_CMD, 32'h40);
    wr(`SB_OFS_THR, 32'h6B);
    peer.clkRun <= 1'b1;
    peer.grab(8, 1, 1'b1, a);
    peer.clkRun <= 1'b0;
    check({21'h0, a}, frame(9'h06B, 8, 1'b0), "external clock frame");
  endtask : t_sync_ext

  // card clock-to-bit ratio from the division and rate codes, nearest integer
  function automatic int cardRatio(input logic [3:0] fiCode, input logic [3:0] diCode);
    int fi;
    int di;
    case (fiCode)
      4'h0, 4'h1: fi = 372;
      4'h2:       fi = 558;
      4'h3:       fi = 744;
      4'h4:       fi = 1116;
      4'h5:       fi = 1488;
      4'h6:       fi = 1860;
      4'h9:       fi = 512;
      4'hA:       fi = 768;
      4'hB:       fi = 1024;
      4'hC:       fi = 1536;
      default:    fi = 2048;
    endcase
    di = (diCode == 4'h8) ? 12 : (diCode == 4'h9) ? 20 : 1 << (diCode - 4'h1);
    cardRatio = (2 * fi + di) / (2 * di);
  endfunction : cardRatio

  // card clock is master clock over two; 372/32 rounds to a 12-clock bit
  task t_card;
    logic [10:0] a;
    int          n;
    wr(`SB_OFS_RATIO, cardRatio(4'h1, 4'h6));
    wr(`SB_OFS_DIV, 32'h2);
    wr(`SB_OFS_MODE, MODE_CARD);
    wr(`SB_OFS_CMD, 32'h40);
    fork
      peer.grab(8, 24, 1'b0, a);
      wr(`SB_OFS_THR, 32'hC3);
    join
    check({21'h0, a}, frame(9'h0C3, 8, 1'b0), "card frame");
    n = 0;
    repeat (20)
    begin
      @(posedge core_clk);
      n += sckOut;
    end
    check(n, 10, "card clock duty");
    check({31'h0, sckOe}, 32'h1, "card clock driven");
  endtask : t_card

  task end_sim;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    rst_n      = 1'b0;
    address    = 8'h0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'hF;
    mismatches = 0;
    checkCount = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset_state();
    t_async_disable();
    t_nine_msb();
    t_soft_reset();
    t_receive();
    t_sync_ext();
    t_card();
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
endmodule : strbc_core_tb
